// *** src/nsoc_pkg.sv ***
package nsoc_pkg;
  // Command opcodes
  localparam logic [7:0] CMD_WREN     = 8'h06;
  localparam logic [7:0] CMD_WRDI     = 8'h04;
  localparam logic [7:0] CMD_GETF     = 8'h0F;
  localparam logic [7:0] CMD_SETF     = 8'h1F;
  localparam logic [7:0] CMD_PEXEC    = 8'h10;
  localparam logic [7:0] CMD_PREAD    = 8'h13;
  localparam logic [7:0] CMD_ERASE    = 8'hD8;
  localparam logic [7:0] CMD_RESET    = 8'hFF;
  localparam logic [7:0] CMD_BLK_LOCK = 8'h36;
  localparam logic [7:0] CMD_BLK_UNLK = 8'h39;
  localparam logic [7:0] CMD_GLB_LOCK = 8'h7E;
  localparam logic [7:0] CMD_GLB_UNLK = 8'h98;
  // Feature addresses
  localparam logic [7:0] FA_OTP       = 8'hB0;
  localparam logic [7:0] FA_STAT      = 8'hC0;
  // Status byte fields
  localparam int         ST_BUSY      = 0;
  localparam int         ST_WR_LATCH  = 1;
  localparam int         ST_EFAIL     = 2;
  localparam int         ST_PFAIL     = 3;
  localparam int         ST_ECC_LSB   = 4;
  localparam logic [2:0] ECC_NONE     = 3'h0;
  // OTP feature fields and reset value
  localparam int         OF_ECC_EN    = 4;
  localparam int         OF_WPS       = 5;
  localparam int         OF_EN        = 6;
  localparam int         OF_PRT       = 7;
  localparam logic [7:0] OTPF_RST     = 8'h10;
  // OTP region geometry and row address width
  localparam logic [5:0] OTP_PAGES    = 6'h08;
  localparam int         OTP_PG_BYTES = 2176;
  localparam int         ROW_W        = 17;
  // Timing
  localparam int         CLK_NS       = 25;
  localparam int         RST_TIME_NS  = 5000;
  localparam int         RST_CYC      = (RST_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int         RST_W        = $clog2(RST_CYC + 1);
  localparam logic [4:0] PUB_HOLD     = 5'h10;

  typedef enum logic [2:0] {
    OP_PROG, OP_READ, OP_ERASE, OP_BLK_LOCK, OP_BLK_UNLK, OP_GLB_LOCK, OP_GLB_UNLK
  } nsoc_op_t;
endpackage : nsoc_pkg

// *** src/nsoc_sync.sv ***
`timescale 1ns/1ps
module nsoc_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic srst_n,
  input  wire logic d,
  output logic      lvl,
  output logic      chg
);
  logic s1_q, s2_q, s3_q;

  // Three stages; a change counts once the second and third agree
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      lvl  <= RST_VAL;
      chg  <= 1'b0;
    end else if (!srst_n) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      lvl  <= RST_VAL;
      chg  <= 1'b0;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      chg  <= (s2_q == s3_q) && (s3_q != lvl);
      if (s2_q == s3_q) begin
        lvl <= s3_q;
      end
    end
  end
endmodule : nsoc_sync

// *** src/nsoc_link.sv ***
`timescale 1ns/1ps
module nsoc_link (
  input  wire logic       sck,
  input  wire logic       cs_n,
  input  wire logic       mosi,
  input  wire logic       resetn,
  input  wire logic [7:0] stat_in,
  input  wire logic [7:0] otpf_in,
  input  wire logic       pub_tgl,
  output logic [7:0]      rx_byte,
  output logic            rx_tgl,
  output logic            miso,
  output logic            miso_oe_n
);
  import nsoc_pkg::*;

  logic [6:0] sh_q;
  logic [2:0] bit_q;
  logic [1:0] idx_q;
  logic [7:0] op_q;
  logic [1:0] sel_q;
  logic [2:0] cnt_n_q;
  logic [7:0] stat_cp_q;
  logic [7:0] otpf_cp_q;
  logic [7:0] rx_w;
  logic [7:0] tx_w;
  logic       pub_chg;

  assign rx_w = {sh_q, mosi};

  // Snapshot toggle from the system domain
  nsoc_sync #(.RST_VAL(1'b0)) u_pub_sync (
    .clk    (sck),
    .arst_n (resetn),
    .srst_n (1'b1),
    .d      (pub_tgl),
    .lvl    (),
    .chg    (pub_chg)
  );

  // Frame shifter, cleared while chip select is high
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      sh_q  <= 7'h00;
      bit_q <= 3'h0;
      idx_q <= 2'h0;
      op_q  <= 8'h00;
      sel_q <= 2'h0;
    end else begin
      sh_q  <= rx_w[6:0];
      bit_q <= bit_q + 3'h1;
      if (bit_q == 3'h7) begin
        if (idx_q != 2'h3) begin
          idx_q <= idx_q + 2'h1;
        end
        if (idx_q == 2'h0) begin
          op_q <= rx_w;
        end
        if (idx_q == 2'h1 && op_q == CMD_GETF) begin
          sel_q <= (rx_w == FA_STAT) ? 2'h1 : (rx_w == FA_OTP) ? 2'h2 : 2'h3; // R19
        end
      end
    end
  end

  // Completed bytes handed to the system domain by toggle
  always_ff @(posedge sck or negedge resetn) begin
    if (!resetn) begin
      rx_byte <= 8'h00;
      rx_tgl  <= 1'b0;
    end else if (bit_q == 3'h7) begin
      rx_byte <= rx_w;
      rx_tgl  <= ~rx_tgl;
    end
  end

  // Local copy of status and OTP feature bytes; the published word is frozen
  // during a frame, so the end of the opcode byte is a safe point to take it
  always_ff @(posedge sck or negedge resetn) begin
    if (!resetn) begin
      stat_cp_q <= 8'h00;
      otpf_cp_q <= OTPF_RST;
    end else if (pub_chg || (bit_q == 3'h7 && idx_q == 2'h0)) begin
      stat_cp_q <= stat_in;
      otpf_cp_q <= otpf_in;
    end
  end

  always_comb begin
    unique case (sel_q)
      2'h1:    tx_w = stat_cp_q;
      2'h2:    tx_w = otpf_cp_q;
      default: tx_w = 8'h00;
    endcase
  end

  // Feature byte out on falling edges, repeating MSB first
  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      miso      <= 1'b0;
      miso_oe_n <= 1'b1;
      cnt_n_q   <= 3'h0;
    end else if (sel_q != 2'h0) begin
      miso      <= tx_w[3'h7 - cnt_n_q]; // R19
      miso_oe_n <= 1'b0;
      cnt_n_q   <= cnt_n_q + 3'h1;
    end
  end
endmodule : nsoc_link

// *** src/nsoc_top.sv ***
`timescale 1ns/1ps
// Functional notes
// R1: Program fail flag sets on failed program, invalid address or protected region.
// R2: Program fail flag clears on program-execute opcode and on reset command.
// R3: Erase fail flag sets on failed erase, including locked-region attempts.
// R4: Erase fail flag clears on block-erase opcode and on reset command.
// R5: Host must set write-enable latch before program-execute or block-erase.
// R6: Write-enable command sets the latch; write-disable clears it.
// R7: Operation-in-progress high during program, read, erase, reset and lock operations.
// R8: Three-bit ECC result field reports array ECC outcome codes.
// R9: Host should refresh a block when ECC result reads 110b.
// R10: ECC result clears on reset and read start, updates on valid completion.
// R11: Host ignores ECC result while internal ECC is disabled.
// R12: OTP region has eight good pages of 2176 bytes each.
// R13: OTP protection bit resets cleared, region writable until locked.
// R14: Host sets OTP enable at B0h, then programs pages 00h-07h in order.
// R15: With OTP enabled, program and read commands target OTP pages.
// R16: After bits 6 and 7 are committed, OTP programming is refused.
// R17: Enable plus protect, write enable, program execute locks OTP permanently.
// R18: Protection already set at power-on leaves OTP read-only.
// R19: Get-features 0Fh with address C0h returns the status byte.
// R20: With OTP enable clear, program and read go to the main array.
module nsoc_top (
  input  wire logic                 clk,
  input  wire logic                 resetn,
  input  wire logic                 sck,
  input  wire logic                 cs_n,
  input  wire logic                 mosi,
  output logic                      miso,
  output logic                      miso_oe_n,
  input  wire logic                 otp_lock_strap,
  input  wire logic                 arr_done,
  input  wire logic                 arr_fail,
  input  wire logic [2:0]           arr_ecc,
  output logic                      arr_req,
  output nsoc_pkg::nsoc_op_t        arr_op,
  output logic [nsoc_pkg::ROW_W-1:0] arr_row,
  output logic                      arr_otp,
  output logic                      arr_abort,
  output logic                      otp_burn,
  output logic                      ecc_en,
  output logic                      wps_sel
);
  import nsoc_pkg::*;

  logic             cs_lvl, cs_chg, rx_chg;
  logic [7:0]       rx_byte;
  logic             rx_tgl;
  logic             frame_start, frame_end;
  logic [2:0]       idx_q;
  logic [7:0]       op_q, fa_q;
  logic [23:0]      row_q;
  logic [1:0]       fe_q;
  logic             start_op, rst_cmd, act_idle, addr_ok, page_bad;
  logic             wr_latch_q, pfail_q, efail_q, busy_q, locked_q;
  logic [2:0]       ecc_q;
  logic             otp_en_q, otp_prot_q, wps_q, ecc_en_q;
  logic [RST_W-1:0] rst_cnt_q;
  logic             busy_any, done_v;
  logic             prog_ok, otp_lock_go, otp_blocked, otp_bad;
  logic             go, go_otp;
  nsoc_op_t         go_op;
  logic [7:0]       stat_w, otpf_w;
  logic [15:0]      pub_q;
  logic             pub_tgl_q;
  logic [4:0]       hold_q;

  // Link-clock side: shifter and feature readout
  nsoc_link u_link (
    .sck       (sck),
    .cs_n      (cs_n),
    .mosi      (mosi),
    .resetn    (resetn),
    .stat_in   (pub_q[7:0]),
    .otpf_in   (pub_q[15:8]),
    .pub_tgl   (pub_tgl_q),
    .rx_byte   (rx_byte),
    .rx_tgl    (rx_tgl),
    .miso      (miso),
    .miso_oe_n (miso_oe_n)
  );

  // Chip select into the system domain
  nsoc_sync #(.RST_VAL(1'b1)) u_cs_sync (
    .clk    (clk),
    .arst_n (1'b1),
    .srst_n (resetn),
    .d      (cs_n),
    .lvl    (cs_lvl),
    .chg    (cs_chg)
  );

  // Byte toggle into the system domain
  nsoc_sync #(.RST_VAL(1'b0)) u_rx_sync (
    .clk    (clk),
    .arst_n (1'b1),
    .srst_n (resetn),
    .d      (rx_tgl),
    .lvl    (),
    .chg    (rx_chg)
  );

  // Frame and command decode terms
  assign frame_start = cs_chg & ~cs_lvl;
  assign frame_end   = cs_chg & cs_lvl;
  assign start_op    = rx_chg & (idx_q == 3'h0);
  assign rst_cmd     = start_op & (rx_byte == CMD_RESET);
  assign busy_any    = busy_q | (rst_cnt_q != '0);
  assign act_idle    = fe_q[1] & ~busy_any;
  assign addr_ok     = (idx_q >= 3'h4);
  assign page_bad    = (row_q[5:0] >= OTP_PAGES); // R12
  assign done_v      = busy_q & arr_done & ~rst_cmd;

  // Byte position, opcode, feature address and row address
  always_ff @(posedge clk) begin
    if (!resetn) begin
      idx_q <= 3'h0;
      op_q  <= 8'h00;
      fa_q  <= 8'h00;
      row_q <= 24'h000000;
    end else if (frame_start) begin
      idx_q <= 3'h0;
    end else if (rx_chg) begin
      if (idx_q != 3'h7) begin
        idx_q <= idx_q + 3'h1;
      end
      if (idx_q == 3'h0) begin
        op_q <= rx_byte;
      end
      if (idx_q == 3'h1) begin
        fa_q <= rx_byte;
      end
      if (idx_q >= 3'h1 && idx_q <= 3'h3) begin
        row_q <= {row_q[15:0], rx_byte};
      end
    end
  end

  // Frame end acted on two cycles late, after any last byte
  always_ff @(posedge clk) begin
    if (!resetn) begin
      fe_q <= 2'h0;
    end else begin
      fe_q <= {fe_q[0], frame_end};
    end
  end

  // Program-execute acceptance and its outcomes in OTP mode
  assign prog_ok     = act_idle & addr_ok & (op_q == CMD_PEXEC) & wr_latch_q; // R5
  assign otp_lock_go = prog_ok & otp_en_q & otp_prot_q & ~locked_q; // R17
  assign otp_blocked = prog_ok & otp_en_q & locked_q; // R16
  assign otp_bad     = prog_ok & otp_en_q & ~otp_prot_q & ~locked_q & page_bad;

  // Which array operation starts at frame end
  always_comb begin
    go     = 1'b0;
    go_op  = OP_PROG;
    go_otp = 1'b0;
    if (act_idle) begin
      unique case (op_q)
        CMD_PEXEC: begin
          go     = prog_ok & ~(otp_en_q & (otp_prot_q | locked_q | page_bad));
          go_otp = otp_en_q; // R15 R20
        end
        CMD_PREAD: begin
          go     = addr_ok;
          go_op  = OP_READ;
          go_otp = otp_en_q; // R15 R20
        end
        CMD_ERASE: begin
          go    = addr_ok & wr_latch_q; // R5
          go_op = OP_ERASE;
        end
        CMD_BLK_LOCK: begin
          go    = addr_ok;
          go_op = OP_BLK_LOCK;
        end
        CMD_BLK_UNLK: begin
          go    = addr_ok;
          go_op = OP_BLK_UNLK;
        end
        CMD_GLB_LOCK: begin
          go    = 1'b1;
          go_op = OP_GLB_LOCK;
        end
        CMD_GLB_UNLK: begin
          go    = 1'b1;
          go_op = OP_GLB_UNLK;
        end
        default: go = 1'b0;
      endcase
    end
  end

  // Array request and busy tracking
  always_ff @(posedge clk) begin
    if (!resetn) begin
      arr_req   <= 1'b0;
      arr_op    <= OP_PROG;
      arr_row   <= '0;
      arr_otp   <= 1'b0;
      arr_abort <= 1'b0;
      busy_q    <= 1'b0;
    end else begin
      arr_req   <= go & ~rst_cmd;
      arr_abort <= rst_cmd & busy_q;
      if (rst_cmd) begin
        busy_q <= 1'b0;
      end else if (go) begin
        busy_q  <= 1'b1; // R7
        arr_op  <= go_op;
        arr_row <= row_q[ROW_W-1:0];
        arr_otp <= go_otp;
      end else if (arr_done) begin
        busy_q <= 1'b0;
      end
    end
  end

  // Reset command busy time
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rst_cnt_q <= '0;
    end else if (rst_cmd) begin
      rst_cnt_q <= RST_W'(RST_CYC); // R7
    end else if (rst_cnt_q != '0) begin
      rst_cnt_q <= rst_cnt_q - 1'b1;
    end
  end

  // Program fail flag; a set wins over a clear
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pfail_q <= 1'b0;
    end else begin
      if ((start_op && rx_byte == CMD_PEXEC) || rst_cmd) begin
        pfail_q <= 1'b0; // R2
      end
      if (otp_blocked || otp_bad || (done_v && arr_op == OP_PROG && arr_fail)) begin
        pfail_q <= 1'b1; // R1
      end
    end
  end

  // Erase fail flag; a set wins over a clear
  always_ff @(posedge clk) begin
    if (!resetn) begin
      efail_q <= 1'b0;
    end else begin
      if ((start_op && rx_byte == CMD_ERASE) || rst_cmd) begin
        efail_q <= 1'b0; // R4
      end
      if (done_v && arr_op == OP_ERASE && arr_fail) begin
        efail_q <= 1'b1; // R3
      end
    end
  end

  // Write-enable latch, dropped once a program or erase finishes
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wr_latch_q <= 1'b0;
    end else begin
      if ((fe_q[1] && op_q == CMD_WRDI) ||
          (done_v && (arr_op == OP_PROG || arr_op == OP_ERASE)) || otp_lock_go) begin
        wr_latch_q <= 1'b0; // R6
      end
      if (fe_q[1] && op_q == CMD_WREN) begin
        wr_latch_q <= 1'b1; // R6
      end
    end
  end

  // ECC result field
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ecc_q <= ECC_NONE;
    end else if (rst_cmd || (start_op && rx_byte == CMD_PREAD)) begin
      ecc_q <= ECC_NONE; // R10
    end else if (done_v && arr_op == OP_READ && !arr_fail) begin
      ecc_q <= arr_ecc; // R8 R10
    end
  end

  // OTP feature byte written by set-features at B0h
  always_ff @(posedge clk) begin
    if (!resetn) begin
      otp_prot_q <= OTPF_RST[OF_PRT]; // R13
      otp_en_q   <= OTPF_RST[OF_EN];
      wps_q      <= OTPF_RST[OF_WPS];
      ecc_en_q   <= OTPF_RST[OF_ECC_EN];
    end else if (rx_chg && idx_q == 3'h2 && op_q == CMD_SETF && fa_q == FA_OTP) begin
      otp_prot_q <= rx_byte[OF_PRT];
      otp_en_q   <= rx_byte[OF_EN];
      wps_q      <= rx_byte[OF_WPS];
      ecc_en_q   <= rx_byte[OF_ECC_EN];
    end
  end

  // Permanent OTP lock: caught from the strap at reset, set by commit
  always_ff @(posedge clk) begin
    if (!resetn) begin
      locked_q <= otp_lock_strap; // R18
      otp_burn <= 1'b0;
    end else begin
      otp_burn <= otp_lock_go;
      if (otp_lock_go) begin
        locked_q <= 1'b1; // R17
      end
    end
  end

  assign ecc_en  = ecc_en_q;
  assign wps_sel = wps_q;

  // Live status and feature bytes
  assign stat_w = {1'b0, ecc_q, pfail_q, efail_q, wr_latch_q, busy_any}; // R7
  assign otpf_w = {otp_prot_q | locked_q, otp_en_q, wps_q, ecc_en_q, 4'h0}; // R18

  // Publish to the link side between frames only, so a frame sees one frozen word
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pub_q     <= {OTPF_RST, 8'h00};
      pub_tgl_q <= 1'b0;
      hold_q    <= 5'h00;
    end else if (hold_q != 5'h00) begin
      hold_q <= hold_q - 5'h01;
    end else if (cs_lvl && {otpf_w, stat_w} != pub_q) begin
      pub_q     <= {otpf_w, stat_w}; // R19
      pub_tgl_q <= ~pub_tgl_q;
      hold_q    <= PUB_HOLD;
    end
  end

  chk_pfail_clear: assert property (@(posedge clk) disable iff (!resetn)
    start_op && rx_byte == CMD_PEXEC && !busy_q |=> !pfail_q) // R2
    else $error("program fail not cleared by program execute");

  chk_pfail_set: assert property (@(posedge clk) disable iff (!resetn)
    (done_v && arr_op == OP_PROG && arr_fail) || otp_blocked |=> pfail_q) // R1
    else $error("program fail not set");

  chk_efail_flow: assert property (@(posedge clk) disable iff (!resetn)
    start_op && rx_byte == CMD_ERASE && !busy_q |=> !efail_q) // R4
    else $error("erase fail not cleared by erase opcode");

  chk_efail_set: assert property (@(posedge clk) disable iff (!resetn)
    done_v && arr_op == OP_ERASE && arr_fail |=> efail_q) // R3
    else $error("erase fail not set");

  chk_latch_cmds: assert property (@(posedge clk) disable iff (!resetn)
    fe_q[1] && op_q == CMD_WREN |=> wr_latch_q ##1 wr_latch_q || !$stable(fe_q)) // R6
    else $error("write enable latch not set");

  chk_busy_hold: assert property (@(posedge clk) disable iff (!resetn)
    go && !rst_cmd |=> stat_w[ST_BUSY] && arr_req ##1 (busy_q || $past(arr_done))) // R7
    else $error("operation in progress not raised");

  chk_busy_reset: assert property (@(posedge clk) disable iff (!resetn)
    rst_cmd |=> stat_w[ST_BUSY] [*8]) // R7
    else $error("reset busy too short");

  chk_ecc_clear: assert property (@(posedge clk) disable iff (!resetn)
    rst_cmd |=> ecc_q == ECC_NONE) // R10
    else $error("ecc result not cleared");

  chk_ecc_update: assert property (@(posedge clk) disable iff (!resetn)
    done_v && arr_op == OP_READ && !arr_fail && !start_op |=> ecc_q == $past(arr_ecc)) // R8
    else $error("ecc result not updated");

  chk_otp_route: assert property (@(posedge clk) disable iff (!resetn)
    go && !rst_cmd && go_op == OP_READ |=> arr_otp == $past(otp_en_q)) // R15
    else $error("read not routed by OTP enable");

  chk_otp_refuse: assert property (@(posedge clk) disable iff (!resetn)
    otp_blocked |=> !arr_req && pfail_q) // R16
    else $error("locked OTP program not refused");

  chk_otp_lock: assert property (@(posedge clk) disable iff (!resetn)
    locked_q |=> locked_q && otpf_w[OF_PRT]) // R17
    else $error("OTP lock did not stay set");
endmodule : nsoc_top

// *** tb/nsoc_host.sv ***
`timescale 1ns/1ps
module nsoc_host (
  output logic      sck,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso
);
  // Idle link: clock stands low, select high
  initial begin
    sck  = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // Opens a frame; the link clock runs only inside frames
  task automatic start();
    #37 cs_n = 1'b0;
    #40;
  endtask : start
  // One byte each way, MSB first, 80 ns link period, sampled on rising sck
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosi = tx[i];
      #40 sck = 1'b1;
      rx[i] = miso;
      #40 sck = 1'b0;
    end
  endtask : xfer
  // Closes a frame, scrambles the released data line, leaves a long gap
  task automatic stop();
    #40 cs_n = 1'b1;
    mosi = ~mosi;
    #800;
  endtask : stop
endmodule : nsoc_host

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  import nsoc_pkg::*;
  logic                 clk = 1'b0;
  logic                 resetn = 1'b0;
  logic                 otp_lock_strap = 1'b0;
  logic                 arr_done = 1'b0;
  logic                 arr_fail = 1'b0;
  logic [2:0]           arr_ecc = 3'h0;
  logic                 sck, cs_n, mosi, miso, miso_oe_n, miso_w;
  logic                 arr_req, arr_otp, arr_abort, otp_burn, ecc_en, wps_sel;
  nsoc_op_t             arr_op, last_op;
  logic [ROW_W-1:0]     arr_row, last_row;
  logic                 last_otp, fail_cfg = 1'b0;
  logic [2:0]           ecc_cfg = 3'h0;
  logic [7:0]           n_req = 8'h00, n_abort = 8'h00, n_burn = 8'h00, r, st;
  int                   dly = 4, cnt = 0, tick = 0, n_mismatch = 0, n_checks = 0;
  nsoc_op_t             ops [7] = '{OP_PROG, OP_READ, OP_ERASE, OP_BLK_LOCK, OP_BLK_UNLK,
                                    OP_GLB_LOCK, OP_GLB_UNLK};
  logic [7:0]           opc [7] = '{CMD_PEXEC, CMD_PREAD, CMD_ERASE, CMD_BLK_LOCK,
                                    CMD_BLK_UNLK, CMD_GLB_LOCK, CMD_GLB_UNLK};

  always #12.5 clk = ~clk;
  // Released data line shows the inverse of mosi, not a constant value
  assign miso_w = (miso_oe_n === 1'b0) ? miso : ~mosi;

  nsoc_top dut (.clk(clk), .resetn(resetn), .sck(sck), .cs_n(cs_n), .mosi(mosi),
    .miso(miso), .miso_oe_n(miso_oe_n), .otp_lock_strap(otp_lock_strap),
    .arr_done(arr_done), .arr_fail(arr_fail), .arr_ecc(arr_ecc), .arr_req(arr_req),
    .arr_op(arr_op), .arr_row(arr_row), .arr_otp(arr_otp), .arr_abort(arr_abort),
    .otp_burn(otp_burn), .ecc_en(ecc_en), .wps_sel(wps_sel));
  nsoc_host host (.sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(miso_w));

  // Array engine model: answers each request after dly cycles, drops it on abort
  always @(negedge clk) begin
    arr_done <= (cnt == 1);
    arr_fail <= (cnt == 1) ? fail_cfg : ~fail_cfg;
    arr_ecc  <= (cnt == 1) ? ecc_cfg : ~ecc_cfg;
    if (cnt > 0) cnt <= cnt - 1;
    if (arr_abort === 1'b1) begin
      cnt     <= 0;
      n_abort <= n_abort + 8'h01;
    end
    if (arr_req === 1'b1) begin
      n_req    <= n_req + 8'h01;
      last_op  <= arr_op;
      last_otp <= arr_otp;
      last_row <= arr_row;
      cnt      <= dly;
    end
    if (otp_burn === 1'b1) n_burn <= n_burn + 8'h01;
    tick <= tick + 1;
    if (tick == 60000) begin
      n_mismatch = n_mismatch + 1;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (n_mismatch == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic rst(input logic strap_v);
    @(negedge clk);
    resetn = 1'b0;
    otp_lock_strap = strap_v;
    repeat (10) @(negedge clk);
    resetn = 1'b1;
    repeat (4) @(negedge clk);
  endtask : rst

  task automatic cmd0(input logic [7:0] op);
    logic [7:0] rx;
    host.start();
    host.xfer(op, rx);
    host.stop();
  endtask : cmd0

  task automatic cmd3(input logic [7:0] op, input logic [23:0] row);
    logic [7:0] rx;
    host.start();
    host.xfer(op, rx);
    for (int i = 2; i >= 0; i--) host.xfer(row[8*i +: 8], rx);
    host.stop();
  endtask : cmd3

  // Write enable, then the modifying command
  task automatic wop(input logic [7:0] op, input logic [23:0] row);
    cmd0(CMD_WREN);
    cmd3(op, row);
  endtask : wop

  task automatic feat(input logic [7:0] op, input logic [7:0] fa, input logic [7:0] d);
    logic [7:0] rx;
    host.start();
    host.xfer(op, rx);
    host.xfer(fa, rx);
    host.xfer(d, st);
    if (op == CMD_GETF) chk("miso_oe_n low", 8'h00, {7'h00, miso_oe_n});
    host.stop();
    chk("miso_oe_n", 8'h01, {7'h00, miso_oe_n});
  endtask : feat

  task automatic rdchk(input string nm, input logic [7:0] fa, input logic [7:0] exp);
    feat(CMD_GETF, fa, 8'h00);
    chk(nm, exp, st);
  endtask : rdchk

  initial begin
    rst(1'b0);
    rdchk("status", FA_STAT, 8'h00);
    rdchk("otp", FA_OTP, OTPF_RST);
    rdchk("unmapped", 8'hA0, 8'h00);
    cmd0(CMD_WREN);
    rdchk("latch set", FA_STAT, 8'h02);
    cmd0(CMD_WRDI);
    rdchk("latch clear", FA_STAT, 8'h00);
    cmd3(CMD_PEXEC, 24'h000123);
    cmd3(CMD_ERASE, 24'h000040);
    chk("refused", 8'h00, n_req);
    // Failure flags set and cleared
    fail_cfg = 1'b1;
    wop(CMD_PEXEC, 24'h000123);
    chk("row", 8'h23, last_row[7:0]);
    chk("otp route", 8'h00, {7'h00, last_otp});
    rdchk("pfail", FA_STAT, 8'h08);
    wop(CMD_ERASE, 24'h000040);
    rdchk("efail", FA_STAT, 8'h0C);
    fail_cfg = 1'b0;
    wop(CMD_PEXEC, 24'h000123);
    rdchk("pfail clr", FA_STAT, 8'h04);
    wop(CMD_ERASE, 24'h000040);
    rdchk("efail clr", FA_STAT, 8'h00);
    // Every ECC result code
    for (int e = 0; e < 8; e++) begin
      ecc_cfg = 3'(e);
      cmd3(CMD_PREAD, 24'h000200);
      rdchk("ecc", FA_STAT, {1'b0, ecc_cfg, 4'h0});
    end
    fail_cfg = 1'b1;
    cmd3(CMD_PREAD, 24'h000200);
    rdchk("ecc start", FA_STAT, 8'h00);
    fail_cfg = 1'b0;
    ecc_cfg = 3'h5;
    cmd3(CMD_PREAD, 24'h000200);
    fail_cfg = 1'b1;
    wop(CMD_PEXEC, 24'h000123);
    rdchk("before reset", FA_STAT, 8'h58);
    // Reset in mid-operation aborts and clears the fail flags and ECC result
    dly = 150;
    wop(CMD_ERASE, 24'h000040);
    cmd0(CMD_RESET);
    fail_cfg = 1'b0;
    repeat (250) @(negedge clk);
    chk("abort", 8'h01, n_abort);
    rdchk("after reset", FA_STAT, 8'h02);
    // Busy flag for every launching command
    for (int i = 0; i < 7; i++) begin
      cmd0(CMD_WREN);
      if (i >= 5) cmd0(opc[i]);
      else cmd3(opc[i], 24'h000080);
      feat(CMD_GETF, FA_STAT, 8'h00);
      chk("busy", 8'h01, {7'h00, st[ST_BUSY]});
      chk("op", {5'h00, ops[i]}, {5'h00, last_op});
      repeat (120) @(negedge clk);
    end
    rdchk("idle", FA_STAT, 8'h52);
    // One-time region access and lock
    dly = 4;
    feat(CMD_SETF, FA_OTP, 8'h70);
    rdchk("otp feat", FA_OTP, 8'h70);
    chk("wps", 8'h01, {7'h00, wps_sel});
    feat(CMD_SETF, FA_OTP, 8'h40);
    chk("ecc_en", 8'h00, {7'h00, ecc_en});
    feat(CMD_SETF, FA_OTP, 8'h50);
    wop(CMD_PEXEC, 24'h000003);
    chk("otp prog", 8'h01, {7'h00, last_otp});
    cmd3(CMD_PREAD, 24'h000007);
    chk("otp read", 8'h01, {7'h00, last_otp});
    chk("otp page", 8'h07, last_row[7:0]);
    r = n_req;
    wop(CMD_PEXEC, 24'h000008);
    chk("page 8", r, n_req);
    rdchk("page 8 fail", FA_STAT, 8'h5A);
    feat(CMD_SETF, FA_OTP, 8'hD0);
    wop(CMD_PEXEC, 24'h000000);
    chk("burn", 8'h01, n_burn);
    chk("burn no req", r, n_req);
    feat(CMD_SETF, FA_OTP, 8'h50);
    rdchk("locked", FA_OTP, 8'hD0);
    wop(CMD_PEXEC, 24'h000001);
    chk("locked prog", r, n_req);
    cmd3(CMD_PREAD, 24'h000001);
    chk("locked read", r + 8'h01, n_req);
    feat(CMD_SETF, FA_OTP, 8'h10);
    wop(CMD_PEXEC, 24'h000005);
    chk("main prog", r + 8'h02, n_req);
    chk("main route", 8'h00, {7'h00, last_otp});
    // Lock already present at power-on
    rst(1'b1);
    rdchk("strap", FA_OTP, 8'h90);
    feat(CMD_SETF, FA_OTP, 8'h50);
    r = n_req;
    wop(CMD_PEXEC, 24'h000002);
    chk("strap prog", r, n_req);
    cmd3(CMD_PREAD, 24'h000002);
    chk("strap read", 8'h01, {7'h00, last_otp});
    print_verdict();
  end
endmodule : tb_top
